// ---- hdl/arith_slice_pkg.sv ----
// Shared constants, types and helpers of the cascadable arithmetic slice
package arith_slice_pkg;

  // ---------------------------------------------------------------------
  // Positions, sequence counters and step counts
  // ---------------------------------------------------------------------
  localparam logic [1:0] POS_MS     = 2'h3; // Most significant slice code
  localparam logic [1:0] SEQ_RESET  = 2'h3; // Counters restart at MS slice
  localparam logic [5:0] STEP_FIRST = 6'h00;
  localparam logic [5:0] STEP_ONE   = 6'h01;

  // ---------------------------------------------------------------------
  // Operation modes held in control bits 1:0
  // ---------------------------------------------------------------------
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_MUL  = 2'h1;
  localparam logic [1:0] MODE_DIV  = 2'h2;

  // Register selection by select bits 1:0
  typedef enum logic [1:0] {
    SEL_OPERAND = 2'b00,
    SEL_ACC_LO  = 2'b01,
    SEL_ACC_HI  = 2'b10,
    SEL_CTRL    = 2'b11
  } reg_sel_t;

  // Run phase of a slice
  typedef enum logic [0:0] {
    PH_IDLE = 1'b0,
    PH_RUN  = 1'b1
  } phase_t;

  // Control word, bit 7 down to bit 0
  typedef struct packed {
    logic       prescale;  // Bit 7: shift clock prescaler
    logic       seq_clear; // Bit 6: restart sequence counters
    logic [1:0] units;     // Bits 5:4: slice count, 0 means four
    logic       clr_hi;    // Bit 3: zero upper accumulator
    logic       clr_lo;    // Bit 2: zero lower accumulator
    logic [1:0] mode;      // Bits 1:0: operation
  } ctrl_word_t;

  localparam ctrl_word_t CTRL_RESET = 8'h00;

  // Host access group
  typedef struct packed {
    logic unit_enable;
    logic read_enable;       // High reads, low writes
    logic access_strobe;
    logic register_select_2;
    logic register_select_1;
    logic register_select_0;
  } access_t;

  // Shift chain pins, one bit per pin
  typedef struct packed {
    logic y_left;
    logic y_right;
    logic z_left;
    logic z_right;
  } chain_pins_t;

  // Whole state of one slice
  typedef struct packed {
    phase_t          phase;
    ctrl_word_t      ctrl;
    logic [7:0]      operand;
    logic [7:0]      acc_lo;
    logic [7:0]      acc_hi;
    logic [3:0][1:0] seq;
    logic [5:0]      step;
    logic            ovf;
    logic            strobe_d;
    logic [7:0]      bus_out;
    logic            bus_oe;
  } slice_state_t;

  localparam slice_state_t STATE_RESET = '{
    phase: PH_IDLE, ctrl: CTRL_RESET, operand: 8'h00, acc_lo: 8'h00,
    acc_hi: 8'h00, seq: {4{SEQ_RESET}}, step: STEP_FIRST, ovf: 1'b0,
    strobe_d: 1'b0, bus_out: 8'h00, bus_oe: 1'b0};

  // State of the shift pulse generator
  typedef struct packed {
    logic [2:0] count;
  } gen_state_t;

  localparam gen_state_t GEN_RESET = '{count: 3'h0};

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  // Number of cascaded slices from the unit-count field
  function automatic logic [2:0] unit_count(input logic [1:0] units);
    return (units == 2'h0) ? 3'h4 : {1'b0, units};
  endfunction

  // Prescaler ratio: 2, 4 or 8 clocks per shift pulse
  function automatic logic [3:0] prescale_ratio(input logic [1:0] units);
    logic [2:0] n;
    n = unit_count(units);
    return (n == 3'h1) ? 4'h2 : ((n == 3'h2) ? 4'h4 : 4'h8);
  endfunction

  // Index of the final step: 8N, so an operation takes 8N+1 pulses
  function automatic logic [5:0] last_step(input logic [1:0] units);
    return {unit_count(units), 3'h0};
  endfunction

endpackage

// ---- hdl/shift_pulse_gen.sv ----
// Shift pulse generator with optional clock prescaler
`timescale 1ns/10ps
`default_nettype none

module shift_pulse_gen (
  // Clock and resets
  input  wire logic       clock,
  input  wire logic       resetn,
  input  wire logic       clear_n,
  // Control
  input  wire logic       run,
  input  wire logic       prescale,
  input  wire logic [1:0] units,
  // Shift pulse out
  output logic            pulse
);

  arith_slice_pkg::gen_state_t g_r;
  arith_slice_pkg::gen_state_t g_nxt;
  logic [3:0]                  ratio;
  logic [2:0]                  top;

  // Prescaler terminal count from the slice count
  assign ratio = arith_slice_pkg::prescale_ratio(units);
  assign top   = 3'(ratio - 4'h1);

  // One pulse per clock, or one per ratio clocks when prescaled
  assign pulse = run & clear_n & (~prescale | (g_r.count == top));

  // Divider count restarts with every pulse and while stopped
  always_comb begin
    g_nxt = g_r;
    if (!run || !clear_n || pulse) begin
      g_nxt.count = 3'h0;
    end else begin
      g_nxt.count = g_r.count + 3'h1;
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      g_r <= arith_slice_pkg::GEN_RESET;
    end else begin
      g_r <= g_nxt;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Unscaled pulses come every clock while running
  no_prescale_a: assert property (
    (run && clear_n && !prescale) |-> pulse)
    else $error("shift pulse missing without prescaler");

  // Divide by eight leaves seven quiet clocks between pulses
  div_eight_a: assert property (
    (pulse && prescale && ratio == 4'h8) |=> !pulse [*7])
    else $error("prescaled pulse spacing wrong");

  // Divide by two gives a pulse every other clock while running
  div_two_a: assert property (
    (pulse && prescale && ratio == 4'h2)
    |=> !pulse ##1 (pulse || !run || !clear_n))
    else $error("divide by two pulse spacing wrong");

endmodule

`default_nettype wire

// ---- hdl/arithmetic_slice.sv ----
// One cascadable 8-bit unsigned multiply/divide arithmetic slice
// Summary of operation
// - Cascade divides 16N by 8N bits, multiplies 8N by 8N to 16N.
// - One to four slices; each operation takes exactly 8N+1 shift pulses.
// - Per-register sequence counter steps per strobe; slice answers on match.
// - Clear input or control bit 6 restarts counters at the top slice.
// - Control bit 7 clear gives one shift pulse per input clock.
// - Prescaler divides clock by 2, 4 or 8 from the unit count.
// - Clear low resets counters, pulse generator and control bits 0 and 1.
// - Repeated accesses to one register walk from top slice downward.
// - Four slices wrap to the top; fewer need a counter reset.
// - Control write starts operation, sets mode, count, clears, prescale.
// - After divide operand unchanged, lower holds quotient, upper remainder.
// - Overflow set when divisor not above the dividend's upper half.
// - Overflow latched per control write; top slice drives it low.
// - Control bit 2 zeroes the lower accumulator.
// - Multiply leaves product high in upper, low in lower accumulator.
// - Multiply adds prior upper accumulator; control bit 3 zeroes it.
// - Unit enable gates selection and the top slice's overflow pin.
// - Lower slices drive their carry out to the next slice.
// - Shared operate-or-shift input says operate or only shift.
// - Select bit 2 and bits 1:0 choose operand, accumulators, status.
// - Writes take bus data at the strobe's falling edge.
// - Status byte holds overflow in bit 0, zeros above.
`timescale 1ns/10ps
`default_nettype none

module arithmetic_slice (
  // Clock and resets
  input  wire logic                          clock,
  input  wire logic                          resetn,
  input  wire logic                          clear_n,
  // Wired position in the cascade
  input  wire logic                          position_code_hi,
  input  wire logic                          position_code_lo,
  // Host access and data bus
  input  wire arith_slice_pkg::access_t      access,
  input  wire logic [7:0]                    bus_i,
  output logic [7:0]                         bus_o,
  output logic                               bus_oe,
  // Cascade carry and control
  input  wire logic                          operate_or_shift_select,
  input  wire logic                          carry_input,
  output logic                               carry_overflow_o,
  output logic                               carry_overflow_oe,
  // Shift chain pins
  input  wire arith_slice_pkg::chain_pins_t  chain_i,
  output var  arith_slice_pkg::chain_pins_t  chain_o,
  output var  arith_slice_pkg::chain_pins_t  chain_oe,
  // Shared shift pulse pin
  input  wire logic                          shift_pulse_i,
  output logic                               shift_pulse_o,
  output logic                               shift_pulse_oe
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  arith_slice_pkg::slice_state_t s_r;
  arith_slice_pkg::slice_state_t s_nxt;
  arith_slice_pkg::reg_sel_t     reg_index;
  logic [1:0]                    position;
  logic [1:0]                    ls_position;
  logic                          is_ms;
  logic                          is_ls;
  logic [5:0]                    last_step;
  logic                          selected;
  logic                          strobe_fall;
  logic                          ctrl_write;
  logic [1:0]                    seq_sel;
  logic                          seq_match;
  logic                          mul_mode;
  logic                          div_mode;
  logic                          stepping;
  logic                          cin;
  logic [8:0]                    mul_sum;
  logic [7:0]                    y_shift;
  logic [8:0]                    div_sub;
  logic                          quot_bit;
  logic                          gen_pulse;

  // -----------------------------------------------------------------------
  // Decode of position, selection and mode
  // -----------------------------------------------------------------------
  assign position    = {position_code_hi, position_code_lo};
  assign is_ms       = position == arith_slice_pkg::POS_MS;
  assign ls_position = 2'(3'h4 - arith_slice_pkg::unit_count(s_r.ctrl.units));
  assign is_ls       = position == ls_position;
  assign last_step   = arith_slice_pkg::last_step(s_r.ctrl.units);
  assign selected    = access.unit_enable & access.register_select_2;
  assign strobe_fall = s_r.strobe_d & ~access.access_strobe;
  assign reg_index   = arith_slice_pkg::reg_sel_t'({access.register_select_1,
                                                   access.register_select_0});
  assign seq_sel     = s_r.seq[reg_index];
  assign seq_match   = seq_sel == position;
  assign ctrl_write  = selected & strobe_fall & ~access.read_enable &
                       (reg_index == arith_slice_pkg::SEL_CTRL);
  assign mul_mode    = s_r.ctrl.mode == arith_slice_pkg::MODE_MUL;
  assign div_mode    = s_r.ctrl.mode == arith_slice_pkg::MODE_DIV;
  assign stepping    = (s_r.phase == arith_slice_pkg::PH_RUN) & shift_pulse_i;

  // -----------------------------------------------------------------------
  // Datapath: adder for multiply, subtractor for divide
  // -----------------------------------------------------------------------
  // Bottom slice injects 0 for add, 1 for subtract; others chain the carry
  assign cin      = is_ls ? div_mode : carry_input;
  assign mul_sum  = {1'b0, s_r.acc_hi} + {8'h00, cin} +
                    (operate_or_shift_select ? {1'b0, s_r.operand}
                                             : 9'h000);
  // First divide pulse compares unshifted, later pulses shift left first
  assign y_shift  = (s_r.step == arith_slice_pkg::STEP_FIRST) ? s_r.acc_hi
                  : {s_r.acc_hi[6:0], chain_i.y_right};
  assign div_sub  = {1'b0, y_shift} + {1'b0, ~s_r.operand} + {8'h00, cin};
  // Quotient bit: bit shifted out of the top or no borrow
  assign quot_bit = s_r.acc_hi[7] | div_sub[8];

  // Chain pins point right in multiply, left in divide, idle otherwise
  always_comb begin
    chain_o  = '0;
    chain_oe = '0;
    if (mul_mode) begin
      chain_o.y_right  = mul_sum[0];
      chain_o.z_right  = s_r.acc_lo[0];
      chain_oe.y_right = 1'b1;
      chain_oe.z_right = 1'b1;
    end else if (div_mode) begin
      chain_o.y_left  = is_ms ? quot_bit : s_r.acc_hi[7];
      chain_o.z_left  = s_r.acc_lo[7];
      chain_oe.y_left = 1'b1;
      chain_oe.z_left = 1'b1;
    end
  end

  // Top slice shows overflow low when enabled; others pass their carry
  assign carry_overflow_o  = is_ms ? ~s_r.ovf
                           : (mul_mode ? mul_sum[8] : div_sub[8]);
  assign carry_overflow_oe = is_ms ? access.unit_enable : 1'b1;

  // Bus and shift pulse pins
  assign bus_o          = s_r.bus_out;
  assign bus_oe         = s_r.bus_oe;
  assign shift_pulse_o  = gen_pulse;
  assign shift_pulse_oe = is_ms;

  // -----------------------------------------------------------------------
  // Shift pulse generator, active on the top slice only
  // -----------------------------------------------------------------------
  shift_pulse_gen u_gen (
    .clock    (clock),
    .resetn   (resetn),
    .clear_n  (clear_n),
    .run      (is_ms & (s_r.phase == arith_slice_pkg::PH_RUN)),
    .prescale (s_r.ctrl.prescale),
    .units    (s_r.ctrl.units),
    .pulse    (gen_pulse)
  );

  // -----------------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------------
  always_comb begin
    s_nxt          = s_r;
    s_nxt.strobe_d = access.access_strobe;
    // One arithmetic step per shift pulse, 8N+1 pulses in all
    if (stepping) begin
      s_nxt.step = s_r.step + arith_slice_pkg::STEP_ONE;
      if (s_r.step == last_step) begin
        s_nxt.phase = arith_slice_pkg::PH_IDLE;
      end
      if (div_mode) begin
        if (s_r.step == arith_slice_pkg::STEP_FIRST) begin
          if (is_ms) begin
            s_nxt.ovf = div_sub[8];
          end
        end else begin
          s_nxt.acc_hi = operate_or_shift_select ? div_sub[7:0]
                                                 : y_shift;
          s_nxt.acc_lo = {s_r.acc_lo[6:0], chain_i.z_right};
        end
      end else if (mul_mode && s_r.step != arith_slice_pkg::STEP_FIRST) begin
        s_nxt.acc_hi = {is_ms ? mul_sum[8] : chain_i.y_left,
                        mul_sum[7:1]};
        s_nxt.acc_lo = {chain_i.z_left, s_r.acc_lo[7:1]};
      end
    end
    // Host access at the strobe's falling edge
    if (selected && strobe_fall) begin
      // Counter walks down from the top slice and wraps after four
      s_nxt.seq[reg_index] = seq_sel - 2'h1;
      if (ctrl_write) begin
        // Every slice takes the control word and starts together
        s_nxt.ctrl  = arith_slice_pkg::ctrl_word_t'(bus_i);
        s_nxt.ovf   = 1'b0;
        s_nxt.step  = arith_slice_pkg::STEP_FIRST;
        s_nxt.phase = (bus_i[1:0] == arith_slice_pkg::MODE_MUL ||
                       bus_i[1:0] == arith_slice_pkg::MODE_DIV)
                    ? arith_slice_pkg::PH_RUN : arith_slice_pkg::PH_IDLE;
        if (s_nxt.ctrl.clr_lo) begin
          s_nxt.acc_lo = 8'h00;
        end
        if (s_nxt.ctrl.clr_hi) begin
          s_nxt.acc_hi = 8'h00;
        end
        if (s_nxt.ctrl.seq_clear) begin
          s_nxt.seq = {4{arith_slice_pkg::SEQ_RESET}};
        end
      end else if (!access.read_enable && seq_match &&
                   s_r.phase == arith_slice_pkg::PH_IDLE) begin
        unique case (reg_index)
          arith_slice_pkg::SEL_OPERAND: s_nxt.operand = bus_i;
          arith_slice_pkg::SEL_ACC_LO:  s_nxt.acc_lo  = bus_i;
          arith_slice_pkg::SEL_ACC_HI:  s_nxt.acc_hi  = bus_i;
          arith_slice_pkg::SEL_CTRL:    s_nxt.acc_hi  = s_r.acc_hi;
        endcase
      end
    end
    // Read data for the selected register
    unique case (reg_index)
      arith_slice_pkg::SEL_OPERAND: s_nxt.bus_out = s_r.operand;
      arith_slice_pkg::SEL_ACC_LO:  s_nxt.bus_out = s_r.acc_lo;
      arith_slice_pkg::SEL_ACC_HI:  s_nxt.bus_out = s_r.acc_hi;
      arith_slice_pkg::SEL_CTRL:    s_nxt.bus_out = {7'h00, s_r.ovf};
    endcase
    s_nxt.bus_oe = selected & access.read_enable & seq_match;
    // Clear input restarts counters, stops the generator, drops the mode
    if (!clear_n) begin
      s_nxt.seq       = {4{arith_slice_pkg::SEQ_RESET}};
      s_nxt.phase     = arith_slice_pkg::PH_IDLE;
      s_nxt.step      = arith_slice_pkg::STEP_FIRST;
      s_nxt.ctrl.mode = arith_slice_pkg::MODE_NONE;
    end
  end

  // State register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_r <= arith_slice_pkg::STATE_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  status_byte_a: assert property (
    (selected && access.read_enable && seq_match &&
     reg_index == arith_slice_pkg::SEL_CTRL)
    |=> (bus_oe && bus_o[7:1] == 7'h00 && bus_o[0] == $past(s_r.ovf)))
    else $error("status byte wrong");

  step_count_a: assert property (
    (stepping && s_r.step != last_step && !ctrl_write && clear_n)
    |=> (s_r.phase == arith_slice_pkg::PH_RUN &&
         s_r.step == $past(s_r.step) + 6'h01))
    else $error("operation step did not advance");

  op_end_a: assert property (
    (stepping && s_r.step == last_step && !ctrl_write && clear_n)
    |=> s_r.phase == arith_slice_pkg::PH_IDLE)
    else $error("operation did not end after 8N+1 pulses");

  seq_step_a: assert property (
    (selected && strobe_fall && !ctrl_write && clear_n)
    |=> s_r.seq[$past(reg_index)] == $past(seq_sel) - 2'h1)
    else $error("sequence counter did not step");

  seq_clear_a: assert property (
    (ctrl_write && bus_i[6])
    |=> s_r.seq == {4{arith_slice_pkg::SEQ_RESET}})
    else $error("control bit 6 did not restart counters");

  clear_pin_a: assert property (
    !clear_n |=> (s_r.ctrl.mode == arith_slice_pkg::MODE_NONE &&
                  s_r.phase == arith_slice_pkg::PH_IDLE &&
                  s_r.seq == {4{arith_slice_pkg::SEQ_RESET}}))
    else $error("clear did not reset slice");

  operand_hold_a: assert property (
    (s_r.phase == arith_slice_pkg::PH_RUN) |=> $stable(s_r.operand))
    else $error("operand changed during operation");

  lo_clear_a: assert property (
    (ctrl_write && bus_i[2]) |=> s_r.acc_lo == 8'h00)
    else $error("lower accumulator not cleared");

  hi_clear_a: assert property (
    (ctrl_write && bus_i[3]) |=> s_r.acc_hi == 8'h00)
    else $error("upper accumulator not cleared");

  overflow_a: assert property (
    (stepping && div_mode && is_ms && s_r.ctrl.units == 2'h1 &&
     s_r.step == 6'h00 && !ctrl_write && clear_n)
    |=> s_r.ovf == ($past(s_r.acc_hi) >= $past(s_r.operand)))
    else $error("overflow flag wrong for single slice");

endmodule

`default_nettype wire

// ---- verif/chain_loop_model.sv ----
// Far-side model: single-slice shift chain loop and shift pulse net
`timescale 1ns/10ps
`default_nettype none

module chain_loop_model (
  // Clock
  input  wire logic                         clock,
  // Slice pin drivers
  input  wire arith_slice_pkg::chain_pins_t chain_o,
  input  wire arith_slice_pkg::chain_pins_t chain_oe,
  input  wire logic                         pulse_o,
  input  wire logic                         pulse_oe,
  // Resolved nets back to the slice
  output var  arith_slice_pkg::chain_pins_t chain_i,
  output logic                              pulse_i,
  output logic                              ctl
);
  logic a_r = 1'b0;
  logic b_r = 1'b0;
  logic p_r = 1'b0;
  logic b;

  // Undriven nets toggle each cycle instead of holding a stale level
  always_comb begin
    ctl = chain_oe.y_left ? chain_o.y_left :
          (chain_oe.z_right ? chain_o.z_right : ~a_r);
    b = chain_oe.y_right ? chain_o.y_right :
        (chain_oe.z_left ? chain_o.z_left : ~b_r);
    chain_i.y_left = ctl;
    chain_i.z_right = ctl;
    chain_i.y_right = b;
    chain_i.z_left = b;
    pulse_i = pulse_oe ? pulse_o : ~p_r;
  end

  // Last level of each net
  always_ff @(posedge clock) begin
    a_r <= ctl;
    b_r <= b;
    p_r <= pulse_i;
  end
endmodule
`default_nettype wire

// ---- verif/arithmetic_slice_tb.sv ----
// Self-checking bench of one slice run as a single-unit cascade
`timescale 1ns/10ps
`default_nettype none

module arithmetic_slice_tb;
  logic                         clock, resetn, clear_n, carry_input;
  arith_slice_pkg::access_t     access;
  arith_slice_pkg::chain_pins_t chain_i, chain_o, chain_oe;
  logic [7:0]                   bus_i, bus_o, rd_v, x, y, z;
  logic                         bus_oe, co_o, co_oe, ctl, ovf, pre;
  logic                         pulse_i, pulse_o, pulse_oe;
  logic [31:0]                  rng;
  logic [15:0]                  full;
  int                           fails, comparisons, np, first, last;

  // Slice wired as the most significant and only unit
  arithmetic_slice arithmetic_slice_i (
    .clock(clock), .resetn(resetn), .clear_n(clear_n),
    .position_code_hi(1'b1), .position_code_lo(1'b1),
    .access(access), .bus_i(bus_i), .bus_o(bus_o), .bus_oe(bus_oe),
    .operate_or_shift_select(ctl), .carry_input(carry_input),
    .carry_overflow_o(co_o), .carry_overflow_oe(co_oe),
    .chain_i(chain_i), .chain_o(chain_o), .chain_oe(chain_oe),
    .shift_pulse_i(pulse_i), .shift_pulse_o(pulse_o),
    .shift_pulse_oe(pulse_oe));

  // Chain loop and pulse net
  chain_loop_model chain_loop_model_i (
    .clock(clock), .chain_o(chain_o), .chain_oe(chain_oe),
    .pulse_o(pulse_o), .pulse_oe(pulse_oe), .chain_i(chain_i),
    .pulse_i(pulse_i), .ctl(ctl));

  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Xorshift step
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Control word: counter restart, one unit
  function automatic logic [7:0] cw(input logic p, input logic ch,
                                    input logic cl, input logic [1:0] m);
    return {p, 1'b1, 2'h1, ch, cl, m};
  endfunction

  // Compare and report
  task automatic chk(input string n, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // One strobed access; read data taken while the strobe is high
  task automatic bus_op(input logic rd, input logic [1:0] sel,
                        input logic [7:0] d);
    @(negedge clock);
    access = {1'b1, rd, 1'b1, 1'b1, sel};
    bus_i = d;
    @(negedge clock);
    rd_v = bus_oe ? bus_o : 8'hxx;
    access.access_strobe = 1'b0;
    @(negedge clock);
    access.register_select_2 = 1'b0;
  endtask

  // Count shift pulses over a bounded window
  task automatic run_wait();
    np = 0;
    for (int k = 0; k < 200; k++) begin
      if (pulse_o === 1'b1) begin
        if (np == 0) first = k;
        np++;
        last = k;
      end
      @(negedge clock);
    end
  endtask

  // Verdict
  task automatic end_of_test();
    if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Main sequence
  initial begin
    rng = 32'h50;
    resetn = 1'b0;
    clear_n = 1'b0;
    carry_input = 1'b0;
    access = '0;
    bus_i = 8'h00;
    fails = 0;
    comparisons = 0;
    repeat (3) @(negedge clock);
    resetn = 1'b1;
    clear_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      rng = xs(rng);
      {carry_input, z, y, x} = rng[24:0];
      pre = i[1];
      if (i == 3) x = y;
      if (x == 8'h00) x = 8'h01;
      bus_op(1'b0, 2'h3, cw(pre, 1'b0, 1'b0, 2'h0));
      bus_op(1'b0, 2'h0, x);
      bus_op(1'b0, 2'h1, z);
      bus_op(1'b0, 2'h2, y);
      bus_op(1'b0, 2'h3, cw(pre, i == 2, i == 5, i[0] ? 2'h2 : 2'h1));
      if (i == 2) y = 8'h00;
      if (i == 5) z = 8'h00;
      run_wait();
      chk("pulses", 16'(np), 16'h9);
      chk("pulse_oe", 16'(pulse_oe), 16'h1);
      chk("span", 16'(last - first), pre ? 16'h10 : 16'h8);
      full = {y, z};
      ovf = i[0] && (x <= y);
      if (!i[0]) full = x * z + y;
      else if (!ovf) full = {8'(full % x), 8'(full / x)};
      bus_op(1'b1, 2'h2, 8'h00);
      if (!ovf) chk("upper", rd_v, full[15:8]);
      bus_op(1'b1, 2'h1, 8'h00);
      if (!ovf) chk("lower", rd_v, full[7:0]);
      bus_op(1'b1, 2'h0, 8'h00);
      chk("operand", rd_v, x);
      bus_op(1'b1, 2'h3, 8'h00);
      if (i[0]) chk("status", rd_v, {7'h00, ovf});
      if (i[0]) chk("ovf_pin", co_o, !ovf);
      bus_op(1'b0, 2'h0, ~x);
      bus_op(1'b0, 2'h3, cw(pre, 1'b0, 1'b0, 2'h0));
      bus_op(1'b1, 2'h0, 8'h00);
      chk("seq_skip", rd_v, x);
      access.unit_enable = i[0];
      @(negedge clock);
      chk("ovf_oe", co_oe, i[0]);
    end
    bus_op(1'b0, 2'h3, cw(1'b0, 1'b0, 1'b0, 2'h3));
    run_wait();
    chk("none_pulses", 16'(np), 16'h0);
    chk("none_chain", 16'(chain_oe), 16'h0);
    bus_op(1'b0, 2'h3, cw(1'b1, 1'b0, 1'b0, 2'h1));
    clear_n = 1'b0;
    @(negedge clock);
    clear_n = 1'b1;
    run_wait();
    chk("clr_pulses", 16'(np), 16'h0);
    chk("clr_chain", 16'(chain_oe), 16'h0);
    end_of_test();
  end
endmodule
`default_nettype wire
